/* File: hdl/csei_regs.vh */
// Register offsets, field positions, reset values and timing for the socket event block
`ifndef CSEI_REGS_VH
`define CSEI_REGS_VH

`define CSEI_SEL_CFG      2'h0
`define CSEI_SEL_LEG      2'h1
`define CSEI_SEL_SOCK     2'h2

`define CSEI_CFG_ROUTE    8'h8c
`define CSEI_CFG_REQ      8'h91
`define CSEI_CFG_DEVCTL   8'h92
`define CSEI_LEG_PWR      8'h02
`define CSEI_LEG_FLAGS    8'h04
`define CSEI_LEG_MASKS    8'h05
`define CSEI_LEG_GCTL     8'h1e
`define CSEI_SOCK_EVENT   8'h00
`define CSEI_SOCK_MASK    8'h04
`define CSEI_SOCK_CTL     8'h10

`define CSEI_BIT_BATTERY_DETECT_ONE     0
`define CSEI_BIT_BATTERY_DETECT_TWO     1
`define CSEI_BIT_READY    2
`define CSEI_BIT_STS      0
`define CSEI_BIT_PWR      3
`define CSEI_BIT_CD1      1
`define CSEI_BIT_CD2      2
`define CSEI_BIT_FUNC     0
`define CSEI_BIT_CLRMODE  2
`define CSEI_BIT_PWRREQ   4
`define CSEI_MODE_LSB     1

`define CSEI_MODE_PCI     2'h0
`define CSEI_MODE_IRQ     2'h1
`define CSEI_MODE_SER     2'h2

`define CSEI_TYPE_NONE    2'h0
`define CSEI_TYPE_MEM     2'h1
`define CSEI_TYPE_IO      2'h2
`define CSEI_TYPE_BUS     2'h3

`define CSEI_RST_MASK     4'h0
`define CSEI_RST_ROUTE    3'h1
`define CSEI_SER_TERM     6

`define CSEI_CLK_PERIOD_NS 32'd10
`define CSEI_PWR_TIME_US   32'd1000
`define CSEI_PWR_CYCLES    ((`CSEI_PWR_TIME_US * 32'd1000 + `CSEI_CLK_PERIOD_NS - 32'd1) / `CSEI_CLK_PERIOD_NS)

`endif

/* File: hdl/csei_sync.v */
// Two-stage pin synchroniser with level, rise and transition outputs
`timescale 1ns/10ps
module csei_sync #(
  parameter W = 5
)(
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] lvl_o,
  output wire [W-1:0] rise_o,
  output wire [W-1:0] chg_o
);
  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;
  reg [1:0]   fill_ff;
  wire        primed;

  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff   <= {W{1'b0}};
      s2_ff   <= {W{1'b0}};
      s3_ff   <= {W{1'b0}};
      fill_ff <= 2'h0;
    end else begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (fill_ff != 2'h3) begin
        fill_ff <= fill_ff + 2'h1;
      end
    end
  end

  // Edges are held off until the pipe holds real pin history, so reset gives no false events
  assign primed = (fill_ff == 2'h3);
  assign lvl_o  = s2_ff;
  assign rise_o = primed ? (s2_ff & ~s3_ff) : {W{1'b0}};
  assign chg_o  = primed ? (s2_ff ^ s3_ff) : {W{1'b0}};
endmodule

/* File: hdl/csei_top.v */
// Card socket event detection, flags, masks and interrupt terminal drive
// Behaviour
// - Memory card battery transitions set flags 0,1
// - Memory card ready transition sets flag 2
// - I/O card status change sets flag 0
// - I/O card request shows unmasked at 91h
// - 16-bit power-up done sets flag 3
// - Bus card status change sets socket bit 0
// - Bus card request shows unmasked at 91h
// - Bus card power-up done sets socket bit 3
// - Insertion or removal sets socket bits 2,1
// - Any detect transition counts, any card type
// - No functional request for memory cards
// - Power-complete comes from internal power sequence
// - Interrupts leave through seven multipurpose terminals
// - PCI lines, parallel IRQ or serial signalling
// - Status change and functional paths kept separate in IRQ and serial modes; PCI mode merges both onto terminal 0
// - Legacy flags clear on read or write-one
// - Socket event flags clear on write-one
`timescale 1ns/10ps
`include "csei_regs.vh"
module csei_top #(
  parameter [31:0] PWR_CYCLES = `CSEI_PWR_CYCLES,
  parameter        CW         = 24
)(
  input  wire       CLK_I,
  input  wire       RST_I,
  input  wire [1:0] CARD_TYPE_I,
  input  wire       BATTERY_DETECT_ONE_I,
  input  wire       BATTERY_DETECT_TWO_I,
  input  wire       READY_REQUEST_I,
  input  wire       CARD_DETECT_ONE_I,
  input  wire       CARD_DETECT_TWO_I,
  input  wire [1:0] REG_SEL_I,
  input  wire [7:0] REG_ADDR_I,
  input  wire       REG_WR_I,
  input  wire       REG_RD_I,
  input  wire [7:0] REG_WDATA_I,
  output reg  [7:0] REG_RDATA_O,
  output reg  [6:0] MULTIPURPOSE_TERMINALS_O,
  output reg  [6:0] MULTIPURPOSE_TERMINALS_OE_N_O,
  output reg        POWER_ON_O
);

  localparam [CW-1:0] PWR_LOAD = PWR_CYCLES[CW-1:0];

  wire [4:0]    pin_lvl;
  wire [4:0]    pin_rise;
  wire [4:0]    pin_chg;
  reg  [3:0]    leg_flag_ff;
  reg  [3:0]    nxt_leg_flag;
  reg  [3:0]    leg_mask_ff;
  reg           clr_mode_ff;
  reg  [3:0]    sock_ev_ff;
  reg  [3:0]    nxt_sock_ev;
  reg  [3:0]    sock_mask_ff;
  reg  [1:0]    mode_ff;
  reg  [2:0]    route_ff;
  reg  [CW-1:0] pwr_cnt_ff;
  reg  [CW-1:0] nxt_pwr_cnt;
  reg           pwr_done_ff;
  reg           nxt_pwr_done;
  reg           nxt_power_on;
  reg  [3:0]    leg_set;
  reg  [3:0]    leg_clr;
  reg  [3:0]    sock_set;
  reg  [3:0]    sock_clr;
  reg  [7:0]    rd_mux;
  reg  [6:0]    nxt_term;
  reg  [6:0]    nxt_oe_n;
  reg           inta;
  wire          is_mem;
  wire          is_io;
  wire          is_bus;
  wire          is_16;
  wire          func_pend;
  wire          csc_any;
  wire          pwr_wr;
  integer       i;

  function hit;
    input [1:0] sel;
    input [7:0] addr;
    input [1:0] want_sel;
    input [7:0] want_addr;
    begin
      hit = (sel == want_sel) && (addr == want_addr);
    end
  endfunction

  // Pins are asynchronous to the bus clock
  csei_sync #(
    .W (5)
  ) u_sync (
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .d_i    ({CARD_DETECT_TWO_I, CARD_DETECT_ONE_I, READY_REQUEST_I,
              BATTERY_DETECT_TWO_I, BATTERY_DETECT_ONE_I}),
    .lvl_o  (pin_lvl),
    .rise_o (pin_rise),
    .chg_o  (pin_chg)
  );

  assign is_mem = (CARD_TYPE_I == `CSEI_TYPE_MEM);
  assign is_io  = (CARD_TYPE_I == `CSEI_TYPE_IO);
  assign is_bus = (CARD_TYPE_I == `CSEI_TYPE_BUS);
  assign is_16  = is_mem | is_io;

  // Shared request pin is ignored while a memory card sits in the socket
  assign func_pend = (is_io | is_bus) & pin_lvl[2];

  // Status change path; the functional path never touches these flags
  assign csc_any = |(leg_flag_ff & leg_mask_ff) | |(sock_ev_ff & sock_mask_ff);

  always @* begin
    leg_set = 4'h0;
    leg_set[`CSEI_BIT_BATTERY_DETECT_ONE]  = is_mem & pin_chg[0];
    leg_set[`CSEI_BIT_BATTERY_DETECT_TWO]  = is_mem & pin_chg[1];
    leg_set[`CSEI_BIT_READY] = is_mem & pin_chg[2];
    if (is_io & pin_rise[0]) begin
      leg_set[`CSEI_BIT_STS] = 1'b1;
    end
    leg_set[`CSEI_BIT_PWR] = is_16 & pwr_done_ff;
  end

  always @* begin
    sock_set = 4'h0;
    sock_set[`CSEI_BIT_STS] = is_bus & pin_rise[0];
    sock_set[`CSEI_BIT_CD1] = pin_chg[3];
    sock_set[`CSEI_BIT_CD2] = pin_chg[4];
    sock_set[`CSEI_BIT_PWR] = is_bus & pwr_done_ff;
  end

  // A set in the clearing cycle wins, so no event is lost
  always @* begin
    leg_clr = 4'h0;
    if (clr_mode_ff) begin
      if (REG_WR_I && hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_LEG, `CSEI_LEG_FLAGS)) begin
        leg_clr = REG_WDATA_I[3:0];
      end
    end else begin
      if (REG_RD_I && hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_LEG, `CSEI_LEG_FLAGS)) begin
        leg_clr = 4'hf;
      end
    end
    nxt_leg_flag = (leg_flag_ff & ~leg_clr) | leg_set;
  end

  always @* begin
    sock_clr = 4'h0;
    if (REG_WR_I && hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_SOCK, `CSEI_SOCK_EVENT)) begin
      sock_clr = REG_WDATA_I[3:0];
    end
    nxt_sock_ev = (sock_ev_ff & ~sock_clr) | sock_set;
  end

  // Power-up sequence: a host request on an occupied socket runs a settle timer
  assign pwr_wr = REG_WR_I &&
                  (hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_LEG, `CSEI_LEG_PWR) ||
                   hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_SOCK, `CSEI_SOCK_CTL));

  always @* begin
    nxt_power_on = POWER_ON_O;
    nxt_pwr_cnt  = pwr_cnt_ff;
    nxt_pwr_done = 1'b0;
    if (pwr_wr) begin
      nxt_power_on = REG_WDATA_I[`CSEI_BIT_PWRREQ];
      if (REG_WDATA_I[`CSEI_BIT_PWRREQ] && !POWER_ON_O) begin
        nxt_pwr_cnt = PWR_LOAD;
      end
    end
    if (nxt_power_on && pwr_cnt_ff != {CW{1'b0}}) begin
      nxt_pwr_cnt = pwr_cnt_ff - {{(CW-1){1'b0}}, 1'b1};
      nxt_pwr_done = (pwr_cnt_ff == {{(CW-1){1'b0}}, 1'b1});
    end
    // Removal drops power and abandons a sequence in flight
    if (CARD_TYPE_I == `CSEI_TYPE_NONE || !nxt_power_on) begin
      nxt_power_on = 1'b0;
      nxt_pwr_cnt  = {CW{1'b0}};
      nxt_pwr_done = 1'b0;
    end
  end

  always @(posedge CLK_I) begin
    if (RST_I) begin
      leg_flag_ff  <= 4'h0;
      leg_mask_ff  <= `CSEI_RST_MASK;
      clr_mode_ff  <= 1'b0;
      sock_ev_ff   <= 4'h0;
      sock_mask_ff <= `CSEI_RST_MASK;
      mode_ff      <= `CSEI_MODE_PCI;
      route_ff     <= `CSEI_RST_ROUTE;
      pwr_cnt_ff   <= {CW{1'b0}};
      pwr_done_ff  <= 1'b0;
      POWER_ON_O   <= 1'b0;
    end else begin
      leg_flag_ff <= nxt_leg_flag;
      sock_ev_ff  <= nxt_sock_ev;
      pwr_cnt_ff  <= nxt_pwr_cnt;
      pwr_done_ff <= nxt_pwr_done;
      POWER_ON_O  <= nxt_power_on;
      if (REG_WR_I) begin
        if (hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_LEG, `CSEI_LEG_MASKS)) begin
          leg_mask_ff <= REG_WDATA_I[3:0];
        end
        if (hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_LEG, `CSEI_LEG_GCTL)) begin
          clr_mode_ff <= REG_WDATA_I[`CSEI_BIT_CLRMODE];
        end
        if (hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_SOCK, `CSEI_SOCK_MASK)) begin
          sock_mask_ff <= REG_WDATA_I[3:0];
        end
        if (hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_CFG, `CSEI_CFG_DEVCTL)) begin
          mode_ff <= REG_WDATA_I[`CSEI_MODE_LSB+1:`CSEI_MODE_LSB];
        end
        if (hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_CFG, `CSEI_CFG_ROUTE)) begin
          route_ff <= REG_WDATA_I[2:0];
        end
      end
    end
  end

  always @* begin
    rd_mux = 8'h00;
    if (hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_LEG, `CSEI_LEG_FLAGS)) begin
      rd_mux = {4'h0, leg_flag_ff};
    end
    if (hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_LEG, `CSEI_LEG_MASKS)) begin
      rd_mux = {4'h0, leg_mask_ff};
    end
    if (hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_LEG, `CSEI_LEG_GCTL)) begin
      rd_mux[`CSEI_BIT_CLRMODE] = clr_mode_ff;
    end
    if (hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_LEG, `CSEI_LEG_PWR) ||
        hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_SOCK, `CSEI_SOCK_CTL)) begin
      rd_mux[`CSEI_BIT_PWRREQ] = POWER_ON_O;
    end
    if (hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_SOCK, `CSEI_SOCK_EVENT)) begin
      rd_mux = {4'h0, sock_ev_ff};
    end
    if (hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_SOCK, `CSEI_SOCK_MASK)) begin
      rd_mux = {4'h0, sock_mask_ff};
    end
    if (hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_CFG, `CSEI_CFG_REQ)) begin
      rd_mux[`CSEI_BIT_FUNC] = func_pend;
    end
    if (hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_CFG, `CSEI_CFG_DEVCTL)) begin
      rd_mux[`CSEI_MODE_LSB+1:`CSEI_MODE_LSB] = mode_ff;
    end
    if (hit(REG_SEL_I, REG_ADDR_I, `CSEI_SEL_CFG, `CSEI_CFG_ROUTE)) begin
      rd_mux[2:0] = route_ff;
    end
  end

  // Terminal 0 is the open-drain PCI line; it carries status change in every mode
  always @* begin
    nxt_term = 7'h00;
    nxt_oe_n = 7'h7f;
    inta     = csc_any;
    case (mode_ff)
      `CSEI_MODE_IRQ: begin
        // Route 0 or 7 leaves the functional request unsignalled
        for (i = 1; i < 7; i = i + 1) begin
          if (route_ff == i[2:0]) begin
            nxt_oe_n[i] = 1'b0;
            nxt_term[i] = func_pend;
          end
        end
      end
      `CSEI_MODE_SER: begin
        // Serial framing is done downstream; this terminal feeds it the request level
        nxt_oe_n[`CSEI_SER_TERM] = 1'b0;
        nxt_term[`CSEI_SER_TERM] = func_pend;
      end
      default: begin
        inta = csc_any | func_pend;
      end
    endcase
    nxt_oe_n[0] = ~inta;
  end

  always @(posedge CLK_I) begin
    if (RST_I) begin
      REG_RDATA_O                   <= 8'h00;
      MULTIPURPOSE_TERMINALS_O      <= 7'h00;
      MULTIPURPOSE_TERMINALS_OE_N_O <= 7'h7f;
    end else begin
      if (REG_RD_I) begin
        REG_RDATA_O <= rd_mux;
      end
      MULTIPURPOSE_TERMINALS_O      <= nxt_term;
      MULTIPURPOSE_TERMINALS_OE_N_O <= nxt_oe_n;
    end
  end
endmodule

/* File: tb/csei_assertions.sv */
// Port-level assertions for the socket event block
`timescale 1ns/10ps
module csei_assertions #(
  parameter [31:0] PWR_CYCLES = 32'd8
)(
  input wire       CLK_I,
  input wire       RST_I,
  input wire [1:0] CARD_TYPE_I,
  input wire [1:0] REG_SEL_I,
  input wire [7:0] REG_ADDR_I,
  input wire       REG_WR_I,
  input wire       REG_RD_I,
  input wire [7:0] REG_WDATA_I,
  input wire [7:0] REG_RDATA_O,
  input wire [6:0] MULTIPURPOSE_TERMINALS_O,
  input wire [6:0] MULTIPURPOSE_TERMINALS_OE_N_O,
  input wire       POWER_ON_O
);
  default clocking dc @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wire [6:0] oe_n   = MULTIPURPOSE_TERMINALS_OE_N_O;
  wire [9:0] adr    = {REG_SEL_I, REG_ADDR_I};
  wire       pwr_wr = REG_WR_I && REG_WDATA_I[4] && (adr == 10'h102 || adr == 10'h210);
  reg  [1:0] mode_ff = 2'h0;
  // Terminals lag a mode write by two edges, so checks wait for a settled mode
  always @(posedge CLK_I) begin
    if (RST_I) begin
      mode_ff <= 2'h0;
    end else if (REG_WR_I && adr == 10'h092) begin
      mode_ff <= REG_WDATA_I[2:1];
    end
  end
  AST_TERM0_OPEN_DRAIN: assert property (MULTIPURPOSE_TERMINALS_O[0] == 1'b0)
    else $error("terminal 0 data high");
  AST_PCI_SPARE_IDLE: assert property (mode_ff == 2'h0 && $past(mode_ff) == 2'h0 |-> oe_n[6:1] == 6'h3f)
    else $error("spare terminal driven in PCI mode");
  AST_SER_SPARE_IDLE: assert property (mode_ff == 2'h2 && $past(mode_ff) == 2'h2 |-> oe_n[5:1] == 5'h1f)
    else $error("spare terminal driven in serial mode");
  AST_MEM_NO_FUNC: assert property ((CARD_TYPE_I == 2'h1)[*3] ##0 (REG_RD_I && adr == 10'h091) |=> !REG_RDATA_O[0])
    else $error("request reported for memory card");
  AST_FLAGS_UPPER_ZERO: assert property (REG_RD_I && adr == 10'h104 |=> REG_RDATA_O[7:4] == 4'h0)
    else $error("unused flag bits set");
  AST_RDATA_HOLD: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
    else $error("read data moved without read");
  AST_POWER_ON: assert property (pwr_wr && CARD_TYPE_I != 2'h0 && !POWER_ON_O |=> POWER_ON_O)
    else $error("power request not taken");
  AST_POWER_DROP: assert property (CARD_TYPE_I == 2'h0 |-> ##[1:2] !POWER_ON_O)
    else $error("power kept with empty socket");
  AST_RESET_QUIET: assert property ($fell(RST_I) |-> oe_n == 7'h7f && REG_RDATA_O == 8'h00 && !POWER_ON_O)
    else $error("outputs active after reset");
  COV_POWER: cover property (pwr_wr ##1 POWER_ON_O);
  COV_FUNC: cover property ((REG_RD_I && adr == 10'h091) ##1 REG_RDATA_O[0]);
  COV_TERM: cover property (!oe_n[0]);
endmodule

bind csei_top csei_assertions #(.PWR_CYCLES(PWR_CYCLES)) csei_assertions_i (
  .CLK_I(CLK_I), .RST_I(RST_I), .CARD_TYPE_I(CARD_TYPE_I), .REG_SEL_I(REG_SEL_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_WDATA_I(REG_WDATA_I),
  .REG_RDATA_O(REG_RDATA_O), .MULTIPURPOSE_TERMINALS_O(MULTIPURPOSE_TERMINALS_O),
  .MULTIPURPOSE_TERMINALS_OE_N_O(MULTIPURPOSE_TERMINALS_OE_N_O), .POWER_ON_O(POWER_ON_O)
);

/* File: tb/csei_card.sv */
// Behavioural card in the socket: type and pin levels as commanded
`timescale 1ns/10ps
module csei_card (
  input  wire       clk_i,
  input  wire [1:0] type_i,
  input  wire [4:0] pins_i,
  output reg  [1:0] card_type_o = 2'h0,
  output reg  [4:0] pins_o      = 5'h18
);
  // Empty socket: detect lines rest on pull-ups, the others on pull-downs
  always @(posedge clk_i) begin
    card_type_o <= type_i;
    pins_o      <= (type_i == 2'h0) ? 5'h18 : pins_i;
  end
endmodule

/* File: tb/csei_top_bench.sv */
// Self-checking bench for the socket event block
`timescale 1ns/10ps
module csei_top_bench;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [1:0]  ty  = 2'h0;
  reg  [4:0]  pr  = 5'h00;
  reg  [1:0]  sel = 2'h0;
  reg  [7:0]  adr = 8'h00;
  reg         we  = 1'b0;
  reg         re  = 1'b0;
  reg  [7:0]  wd  = 8'h00;
  reg  [31:0] rnd = 32'hc93ff812;
  wire [1:0]  ct;
  wire [4:0]  pn;
  wire [7:0]  rdata;
  wire [6:0]  td;
  wire [6:0]  oe_n;
  wire        pwr;
  integer     fail_count = 0;
  integer     tests_run  = 0;
  integer     cyc        = 0;
  integer     i;

  always #5 clk = ~clk;

  csei_card csei_card_i (.clk_i(clk), .type_i(ty), .pins_i(pr), .card_type_o(ct), .pins_o(pn));
  csei_top #(.PWR_CYCLES(32'd8)) csei_top_i (
    .CLK_I(clk), .RST_I(rst), .CARD_TYPE_I(ct), .BATTERY_DETECT_ONE_I(pn[0]), .BATTERY_DETECT_TWO_I(pn[1]),
    .READY_REQUEST_I(pn[2]), .CARD_DETECT_ONE_I(pn[3]), .CARD_DETECT_TWO_I(pn[4]), .REG_SEL_I(sel),
    .REG_ADDR_I(adr), .REG_WR_I(we), .REG_RD_I(re), .REG_WDATA_I(wd), .REG_RDATA_O(rdata),
    .MULTIPURPOSE_TERMINALS_O(td), .MULTIPURPOSE_TERMINALS_OE_N_O(oe_n), .POWER_ON_O(pwr));

  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function [7:0] bitv(input integer k);
    bitv = 8'h01 << k;
  endfunction
  function [7:0] low4(input [7:0] x);
    low4 = {4'h0, x[3:0]};
  endfunction

  task close_out;
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk(input string n, input [7:0] s, input [7:0] e);
    tests_run = tests_run + 1;
    if (s !== e) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input [1:0] s, input [7:0] a, input [7:0] d);
    @(posedge clk);
    sel <= s;
    adr <= a;
    wd  <= d;
    we  <= 1'b1;
    @(posedge clk);
    we  <= 1'b0;
  endtask
  task rd(input [1:0] s, input [7:0] a, input [7:0] e);
    @(posedge clk);
    sel <= s;
    adr <= a;
    re  <= 1'b1;
    @(posedge clk);
    re  <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask
  task ot(input integer k, input [7:0] e);
    #1 chk("oe_n", {7'h0, oe_n[k]}, e);
  endtask
  task pc(input [7:0] e);
    #1 chk("power", {7'h0, pwr}, e);
  endtask
  // Pins settle through the model and the two-stage sync before flags move
  task pin(input [7:0] v);
    @(posedge clk);
    pr <= v[4:0];
    wt(8);
  endtask
  task card(input [1:0] t);
    @(posedge clk);
    ty <= t;
    pr <= 5'h00;
    wt(8);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      close_out;
    end
  end

  initial begin
    wt(12);
    rst <= 1'b0;
    wt(4);
    rd(2'h1, 8'h05, 8'h00);
    rd(2'h0, 8'h91, 8'h00);
    rd(2'h1, 8'h1e, 8'h00);
    rd(2'h3, 8'h00, 8'h00);
    card(2'h1);
    rd(2'h2, 8'h00, 8'h06);
    rd(2'h2, 8'h00, 8'h06);
    wr(2'h2, 8'h00, 8'h06);
    rd(2'h2, 8'h00, 8'h00);
    for (i = 0; i < 3; i = i + 1) begin
      pin(bitv(i));
      rd(2'h1, 8'h04, bitv(i));
      rd(2'h1, 8'h04, 8'h00);
      rd(2'h0, 8'h91, 8'h00);
      pin(8'h00);
      rd(2'h1, 8'h04, bitv(i));
    end
    for (i = 0; i < 4; i = i + 1) begin
      rnd = lfsr(rnd);
      wr(2'h1, 8'h05, rnd[7:0]);
      rd(2'h1, 8'h05, low4(rnd[7:0]));
    end
    wr(2'h1, 8'h05, 8'h02);
    pin(8'h01);
    ot(0, 8'h01);
    pin(8'h03);
    ot(0, 8'h00);
    rd(2'h1, 8'h04, 8'h03);
    wt(3);
    ot(0, 8'h01);
    pin(8'h00);
    wr(2'h1, 8'h05, 8'h00);
    rd(2'h1, 8'h04, 8'h03);
    wr(2'h1, 8'h02, 8'h10);
    pc(8'h01);
    wt(20);
    rd(2'h1, 8'h04, 8'h08);
    card(2'h0);
    pc(8'h00);
    rd(2'h2, 8'h00, 8'h06);
    card(2'h2);
    wr(2'h2, 8'h00, 8'h06);
    pin(8'h01);
    rd(2'h1, 8'h04, 8'h01);
    wr(2'h1, 8'h1e, 8'h04);
    rd(2'h1, 8'h1e, 8'h04);
    pin(8'h00);
    pin(8'h01);
    rd(2'h1, 8'h04, 8'h01);
    rd(2'h1, 8'h04, 8'h01);
    wr(2'h1, 8'h04, 8'h01);
    rd(2'h1, 8'h04, 8'h00);
    pin(8'h05);
    rd(2'h0, 8'h91, 8'h01);
    rd(2'h1, 8'h04, 8'h00);
    ot(0, 8'h00);
    wr(2'h0, 8'h8c, 8'h03);
    wr(2'h0, 8'h92, 8'h02);
    wt(2);
    ot(3, 8'h00);
    chk("term", {7'h0, td[3]}, 8'h01);
    wr(2'h0, 8'h92, 8'h04);
    wt(2);
    ot(6, 8'h00);
    chk("term", {7'h0, td[6]}, 8'h01);
    wr(2'h0, 8'h92, 8'h00);
    pin(8'h00);
    rd(2'h0, 8'h91, 8'h00);
    ot(0, 8'h01);
    card(2'h0);
    card(2'h3);
    wr(2'h2, 8'h00, 8'h06);
    pin(8'h01);
    rd(2'h2, 8'h00, 8'h01);
    wr(2'h2, 8'h04, 8'h01);
    wt(3);
    ot(0, 8'h00);
    wr(2'h2, 8'h00, 8'h01);
    rd(2'h2, 8'h00, 8'h00);
    wr(2'h2, 8'h04, 8'h00);
    pin(8'h04);
    rd(2'h0, 8'h91, 8'h01);
    pin(8'h00);
    wr(2'h2, 8'h10, 8'h10);
    wt(20);
    rd(2'h2, 8'h00, 8'h08);
    close_out;
  end
endmodule
